// ==== ocs_pkg.sv ====
// Package for the offline converter sequencer: timing constants, states and carriers.
// Assumes a single 10 MHz clock from the internal oscillator.
package ocs_pkg;

  localparam int unsigned CLK_HZ = 10000000;
  // Nominal switching frequencies of the two variants.
  localparam int unsigned FSW_LOW_HZ = 60000;
  localparam int unsigned FSW_HIGH_HZ = 115000;
  localparam int unsigned JIT_LOW_HZ = 4000;
  localparam int unsigned JIT_HIGH_HZ = 8000;
  localparam int unsigned JIT_RATE_HZ = 250;
  // Soft-start interval in microseconds.
  localparam int unsigned SS_US = 8500;
  localparam int unsigned SS_CYC = SS_US * (CLK_HZ / 1000000);
  localparam int unsigned PER_LOW_CYC = CLK_HZ / FSW_LOW_HZ;
  localparam int unsigned PER_HIGH_CYC = CLK_HZ / FSW_HIGH_HZ;
  // Period swing in cycles for the jitter extremes.
  localparam int unsigned DEV_LOW_CYC = PER_LOW_CYC - CLK_HZ / (FSW_LOW_HZ + JIT_LOW_HZ);
  localparam int unsigned DEV_HIGH_CYC = PER_HIGH_CYC - CLK_HZ / (FSW_HIGH_HZ + JIT_HIGH_HZ);
  localparam int unsigned JIT_HALF_CYC = CLK_HZ / (2 * JIT_RATE_HZ);
  localparam int unsigned OVP_COUNT = 4;
  localparam int unsigned LIM_W = 8;
  localparam logic [LIM_W-1:0] LIM_MAX = 8'hFF;
  localparam logic [LIM_W-1:0] LIM_MIN = 8'h10;
  localparam int unsigned SS_STEP_CYC = SS_CYC / (LIM_MAX - LIM_MIN);
  localparam int unsigned CNT_W = 16;
  localparam int unsigned SYNC_W = 6;

  typedef enum logic [2:0] {
    OCS_LOCKOUT,
    OCS_CHARGE,
    OCS_RUN,
    OCS_HOLD,
    OCS_INHIBIT
  } ocs_state_t;

  // Synchronised comparator results.
  typedef struct packed {
    logic input_start;
    logic turn_on;
    logic turn_off;
    logic restart;
    logic current_trip;
    logic overvoltage;
  } ocs_comp_t;

endpackage : ocs_pkg

// ==== ocs_sync.sv ====
// Three-stage synchroniser for one comparator bit; a change counts once stages two and three agree.
// Assumes an asynchronous level input and the single system clock.
`timescale 1ns/1ps
`default_nettype none
module ocs_sync (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic async_i,
  output logic level_o
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      level_o <= 1'b0;
    end else begin
      s1_r <= async_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level_o <= s3_r;
      end
    end
  end
endmodule : ocs_sync
`default_nettype wire

// ==== ocs_sequencer.sv ====
// Startup, soft-start, oscillator with jitter, current-mode turn-off and overvoltage counter.
// Assumes analog comparators outside as asynchronous levels; the lockout reset is reset_n_i.
// How it works
// [RULE1] Gate held low during supply lockout.
// [RULE2] Charge generator only above input start threshold.
// [RULE3] Normal charge current, reduced after a fault.
// [RULE4] Turn-on threshold starts switching, stops charging.
// [RULE5] Soft-start ramps current limit every start.
// [RULE6] Below turn-off threshold, stop switching.
// [RULE7] Low input after stop inhibits restart.
// [RULE8] Recharge only below low restart threshold.
// [RULE9] Every fault ends in auto-restart; the code latches in inhibit instead if the input drops during hold.
// [RULE10] Oscillator at 60 or 115 kHz.
// [RULE11] Frequency jittered at 250 Hz rate.
// [RULE12] Current compared every switching cycle.
// [RULE13] Current trip ends on-time that cycle.
// [RULE14] Default limit unless adjust current present.
// [RULE15] Overvoltage sampled only during off-time.
// [RULE16] Four consecutive overvoltage cycles declare fault.
// [RULE17] Missing overvoltage cycle clears counter.
// [RULE18] Overvoltage stops switching, restarts as fault.
// [RULE19] All comparators synchronised before use.
`timescale 1ns/1ps
`default_nettype none
module ocs_sequencer (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic high_variant_i,
  input wire logic input_start_i,
  input wire logic turn_on_i,
  input wire logic turn_off_i,
  input wire logic restart_i,
  input wire logic current_trip_i,
  input wire logic overvoltage_i,
  input wire logic limit_adjust_present_i,
  output logic gate_o,
  output logic charge_en_o,
  output logic charge_low_o,
  output logic [ocs_pkg::LIM_W-1:0] drain_current_limit_o,
  output logic limit_external_o,
  output logic fault_o
);
  ocs_pkg::ocs_comp_t comp;
  ocs_pkg::ocs_state_t state_r;
  logic fault_r;
  logic [ocs_pkg::CNT_W-1:0] per_cnt_r;
  logic [ocs_pkg::CNT_W-1:0] period_r;
  logic [ocs_pkg::CNT_W-1:0] jit_off_r;
  logic jit_up_r;
  logic [ocs_pkg::CNT_W-1:0] jit_cnt_r;
  logic [ocs_pkg::CNT_W-1:0] ss_cnt_r;
  logic [ocs_pkg::LIM_W-1:0] limit_r;
  logic on_r;
  logic ov_seen_r;
  logic [2:0] ov_cnt_r;
  logic ov_fault;
  logic cycle_start;
  logic lim_adj;

  // [RULE19] Comparator synchronisers.
  ocs_sync u_s0 (.clk_i(clk_i), .reset_n_i(reset_n_i), .async_i(input_start_i),
    .level_o(comp.input_start));
  ocs_sync u_s1 (.clk_i(clk_i), .reset_n_i(reset_n_i), .async_i(turn_on_i),
    .level_o(comp.turn_on));
  ocs_sync u_s2 (.clk_i(clk_i), .reset_n_i(reset_n_i), .async_i(turn_off_i),
    .level_o(comp.turn_off));
  ocs_sync u_s3 (.clk_i(clk_i), .reset_n_i(reset_n_i), .async_i(restart_i),
    .level_o(comp.restart));
  ocs_sync u_s4 (.clk_i(clk_i), .reset_n_i(reset_n_i), .async_i(current_trip_i),
    .level_o(comp.current_trip));
  ocs_sync u_s5 (.clk_i(clk_i), .reset_n_i(reset_n_i), .async_i(overvoltage_i),
    .level_o(comp.overvoltage));
  ocs_sync u_s6 (.clk_i(clk_i), .reset_n_i(reset_n_i), .async_i(limit_adjust_present_i),
    .level_o(lim_adj));

  function automatic logic [ocs_pkg::CNT_W-1:0] base_period(input logic hi);
    base_period = hi ? ocs_pkg::CNT_W'(ocs_pkg::PER_HIGH_CYC)
                     : ocs_pkg::CNT_W'(ocs_pkg::PER_LOW_CYC);
  endfunction : base_period

  function automatic logic [ocs_pkg::CNT_W-1:0] dev_period(input logic hi);
    dev_period = hi ? ocs_pkg::CNT_W'(ocs_pkg::DEV_HIGH_CYC)
                    : ocs_pkg::CNT_W'(ocs_pkg::DEV_LOW_CYC);
  endfunction : dev_period

  assign cycle_start = (per_cnt_r == '0);
  assign ov_fault = (ov_cnt_r == 3'(ocs_pkg::OVP_COUNT));

  // [RULE11] Triangle sweep of the period offset.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      jit_cnt_r <= '0;
      jit_off_r <= '0;
      jit_up_r <= 1'b1;
    end else if (jit_cnt_r == ocs_pkg::CNT_W'(ocs_pkg::JIT_HALF_CYC - 1)) begin
      jit_cnt_r <= '0;
      jit_up_r <= ~jit_up_r;
    end else begin
      jit_cnt_r <= jit_cnt_r + 1'b1;
      if (cycle_start) begin
        if (jit_up_r && jit_off_r < 2 * dev_period(high_variant_i)) begin
          jit_off_r <= jit_off_r + 1'b1;
        end else if (!jit_up_r && jit_off_r != '0) begin
          jit_off_r <= jit_off_r - 1'b1;
        end
      end
    end
  end

  // [RULE10] Period counter free-runs at the nominal rate.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      per_cnt_r <= '0;
      period_r <= ocs_pkg::CNT_W'(ocs_pkg::PER_LOW_CYC);
    end else if (per_cnt_r >= period_r - 1'b1) begin
      per_cnt_r <= '0;
      period_r <= base_period(high_variant_i) - dev_period(high_variant_i) + jit_off_r;
    end else begin
      per_cnt_r <= per_cnt_r + 1'b1;
    end
  end

  // Sequencing of lockout, charge, run, hold and inhibit.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state_r <= ocs_pkg::OCS_LOCKOUT;
      fault_r <= 1'b0;
    end else begin
      case (state_r)
        ocs_pkg::OCS_LOCKOUT: begin
          // [RULE2] Wait for bulk voltage.
          if (comp.input_start) begin
            state_r <= ocs_pkg::OCS_CHARGE;
          end
        end
        ocs_pkg::OCS_CHARGE: begin
          // [RULE4] Start switching at turn-on threshold.
          if (comp.turn_on) begin
            state_r <= ocs_pkg::OCS_RUN;
          end else if (!comp.input_start) begin
            state_r <= ocs_pkg::OCS_LOCKOUT;
          end
        end
        ocs_pkg::OCS_RUN: begin
          // [RULE18] Overvoltage is a fault stop.
          if (ov_fault) begin
            fault_r <= 1'b1;
            state_r <= ocs_pkg::OCS_HOLD;
          end else if (comp.turn_off) begin
            // [RULE6] Supply collapse stops switching.
            // [RULE7] Low input inhibits a new start.
            state_r <= comp.input_start ? ocs_pkg::OCS_HOLD : ocs_pkg::OCS_INHIBIT;
          end else begin
            fault_r <= 1'b0;
          end
        end
        ocs_pkg::OCS_HOLD: begin
          // [RULE8] Recharge below restart threshold.
          // [RULE9] Auto-restart, unless low input first latches the inhibit.
          if (comp.restart) begin
            state_r <= ocs_pkg::OCS_CHARGE;
          end else if (!comp.input_start) begin
            state_r <= ocs_pkg::OCS_INHIBIT;
          end
        end
        ocs_pkg::OCS_INHIBIT: begin
          // A new power-up leaves the inhibit only through lockout reset.
          state_r <= ocs_pkg::OCS_INHIBIT;
        end
        default: begin
          state_r <= ocs_pkg::OCS_LOCKOUT;
        end
      endcase
    end
  end

  // [RULE5] Soft-start ramp of the limit from the minimum.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      limit_r <= ocs_pkg::LIM_MIN;
      ss_cnt_r <= '0;
    end else if (state_r != ocs_pkg::OCS_RUN) begin
      limit_r <= ocs_pkg::LIM_MIN;
      ss_cnt_r <= '0;
    end else if (limit_r != ocs_pkg::LIM_MAX) begin
      if (ss_cnt_r == ocs_pkg::CNT_W'(ocs_pkg::SS_STEP_CYC - 1)) begin
        ss_cnt_r <= '0;
        limit_r <= limit_r + 1'b1;
      end else begin
        ss_cnt_r <= ss_cnt_r + 1'b1;
      end
    end
  end

  // [RULE12] Switch on each cycle, off on trip.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      on_r <= 1'b0;
    end else if (state_r != ocs_pkg::OCS_RUN || ov_fault || comp.turn_off) begin
      on_r <= 1'b0;
    end else if (cycle_start) begin
      on_r <= 1'b1;
    end else if (comp.current_trip) begin
      // [RULE13] Trip ends the on-time.
      on_r <= 1'b0;
    end
  end

  // [RULE15] Note comparator firing during off-time only.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      ov_seen_r <= 1'b0;
      ov_cnt_r <= '0;
    end else if (state_r != ocs_pkg::OCS_RUN) begin
      ov_seen_r <= 1'b0;
      ov_cnt_r <= '0;
    end else if (cycle_start) begin
      ov_seen_r <= 1'b0;
      if (ov_seen_r) begin
        // [RULE16] Count consecutive firing cycles.
        if (!ov_fault) begin
          ov_cnt_r <= ov_cnt_r + 1'b1;
        end
      end else begin
        // [RULE17] Quiet cycle clears the count.
        ov_cnt_r <= '0;
      end
    end else if (!on_r && comp.overvoltage) begin
      ov_seen_r <= 1'b1;
    end
  end

  // Registered outputs.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      gate_o <= 1'b0;
      charge_en_o <= 1'b0;
      charge_low_o <= 1'b0;
      drain_current_limit_o <= ocs_pkg::LIM_MIN;
      limit_external_o <= 1'b0;
      fault_o <= 1'b0;
    end else begin
      // [RULE1] Gate low outside run.
      gate_o <= on_r && state_r == ocs_pkg::OCS_RUN;
      // [RULE2] Charge only in charge state with input present.
      charge_en_o <= state_r == ocs_pkg::OCS_CHARGE && comp.input_start;
      // [RULE3] Reduced current after a fault.
      charge_low_o <= fault_r;
      drain_current_limit_o <= limit_r;
      // [RULE14] External limit only with adjust current.
      limit_external_o <= lim_adj;
      fault_o <= fault_r;
    end
  end

  // [RULE1] Gate stays low outside run.
  gate_lockout_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE1]
    state_r != ocs_pkg::OCS_RUN |=> !gate_o)
    else $error("gate high outside run");

  // [RULE4] No charging while running.
  run_no_charge_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE4]
    state_r == ocs_pkg::OCS_RUN |=> !charge_en_o)
    else $error("charge active while running");

  // [RULE16] Fault after four counted cycles.
  ovp_fault_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE16]
    state_r == ocs_pkg::OCS_RUN && ov_fault |=> state_r == ocs_pkg::OCS_HOLD && fault_r)
    else $error("overvoltage not declared");

  // [RULE17] Quiet cycle clears the count.
  ovp_clear_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE17]
    state_r == ocs_pkg::OCS_RUN && cycle_start && !ov_seen_r |=> ov_cnt_r == 3'd0)
    else $error("overvoltage count not cleared");

  // [RULE15] Firing during on-time is ignored.
  ovp_offtime_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE15]
    !cycle_start && on_r && !ov_seen_r |=> !ov_seen_r)
    else $error("overvoltage sampled in on-time");

  // [RULE7] Inhibit is permanent until reset.
  inhibit_hold_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE7]
    state_r == ocs_pkg::OCS_INHIBIT |=> state_r == ocs_pkg::OCS_INHIBIT ##1 !charge_en_o)
    else $error("restart after inhibit");

  // [RULE3] Charge level follows fault flag.
  charge_level_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE3]
    fault_r |=> charge_low_o)
    else $error("reduced charge not selected");

  // [RULE5] Limit starts at minimum.
  ss_start_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE5]
    state_r != ocs_pkg::OCS_RUN |=> limit_r == ocs_pkg::LIM_MIN)
    else $error("soft-start not restarted");

  // [RULE13] Trip ends the on-time.
  trip_off_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE13]
    on_r && comp.current_trip && !cycle_start |=> !on_r)
    else $error("switch not turned off on trip");

  // [RULE2] Charging needs the bulk input.
  charge_input_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE2]
    !comp.input_start |=> !charge_en_o)
    else $error("charge without input");

  // [RULE4] Turn-on threshold starts the run.
  charge_start_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE4]
    state_r == ocs_pkg::OCS_CHARGE && comp.turn_on |=> state_r == ocs_pkg::OCS_RUN)
    else $error("run not started");

  // [RULE6] Supply collapse turns the switch off.
  supply_stop_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE6]
    state_r == ocs_pkg::OCS_RUN && comp.turn_off |=> !on_r)
    else $error("switching below turn-off");

  // [RULE8] No recharge above restart threshold.
  restart_wait_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE8]
    state_r == ocs_pkg::OCS_HOLD && !comp.restart |=> state_r != ocs_pkg::OCS_CHARGE)
    else $error("recharge above restart threshold");

  // [RULE9] Restart threshold always recharges.
  auto_restart_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE9]
    state_r == ocs_pkg::OCS_HOLD && comp.restart |=> state_r == ocs_pkg::OCS_CHARGE)
    else $error("no auto-restart");

  // [RULE5] Limit never falls during a run.
  ss_ramp_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE5]
    state_r == ocs_pkg::OCS_RUN && $past(state_r) == ocs_pkg::OCS_RUN |-> limit_r >= $past(limit_r))
    else $error("soft-start limit fell");

  // [RULE10] Period never below the jitter minimum.
  osc_period_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE10]
    cycle_start |-> period_r >= base_period(high_variant_i) - dev_period(high_variant_i))
    else $error("period too short");

  // [RULE12] Each cycle start turns the switch on.
  cycle_on_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE12]
    state_r == ocs_pkg::OCS_RUN && cycle_start && !ov_fault && !comp.turn_off |=> on_r)
    else $error("cycle start missed");

  // [RULE14] Limit selection follows the adjust current.
  ext_limit_a: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [RULE14]
    lim_adj |=> limit_external_o)
    else $error("external limit not applied");

endmodule : ocs_sequencer
`default_nettype wire

// ==== ocs_stage_model.sv ====
// Behavioural power stage: supply capacitor, comparators and current sense.
// Assumes the sequencer's outputs and one clock; the bench steers bulk, aux and overvoltage.
`timescale 1ns/1ps
`default_nettype none
module ocs_stage_model (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic gate_i,
  input wire logic charge_en_i,
  input wire logic charge_low_i,
  input wire logic bulk_i,
  input wire logic aux_ok_i,
  input wire logic ovp_cmd_i,
  output logic input_start_o,
  output logic turn_on_o,
  output logic turn_off_o,
  output logic restart_o,
  output logic current_trip_o,
  output logic overvoltage_o
);
  // Supply in arbitrary units; the reduced charge rate is a fifth of the normal one.
  int vdd;
  int on_cnt;
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      vdd <= 0;
    end else if (charge_en_i) begin
      vdd <= vdd + (charge_low_i ? 1 : 5);
    end else if (!aux_ok_i && vdd > 0) begin
      vdd <= vdd - 1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (!reset_n_i || !gate_i) begin
      on_cnt <= 0;
    end else begin
      on_cnt <= on_cnt + 1;
    end
  end
  assign input_start_o = bulk_i;
  assign turn_on_o = vdd >= 1000;
  assign turn_off_o = vdd < 600;
  assign restart_o = vdd < 300;
  assign current_trip_o = on_cnt >= 20;
  // The auxiliary winding only mirrors the output while the switch is off.
  assign overvoltage_o = ovp_cmd_i && !gate_i;
endmodule : ocs_stage_model
`default_nettype wire

// ==== offline_converter_sequencer_test.sv ====
// Self-checking bench for the converter sequencer against a behavioural power stage.
// Assumes ocs_pkg, ocs_sequencer and ocs_stage_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module offline_converter_sequencer_test;
  logic clk_i = 0;
  logic reset_n_i = 0;
  logic high_variant_i = 0;
  logic limit_adjust_present_i = 0;
  logic bulk = 0;
  logic aux_ok = 1;
  logic ovp_cmd = 0;
  logic input_start, turn_on, turn_off, restart, current_trip, overvoltage;
  logic gate_o, charge_en_o, charge_low_o, limit_external_o, fault_o;
  logic [ocs_pkg::LIM_W-1:0] drain_current_limit_o;
  int mismatches = 0;
  int n_checks = 0;

  initial forever #50 clk_i = ~clk_i;

  ocs_sequencer ocs_sequencer_i (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .high_variant_i(high_variant_i), .input_start_i(input_start), .turn_on_i(turn_on),
    .turn_off_i(turn_off), .restart_i(restart), .current_trip_i(current_trip),
    .overvoltage_i(overvoltage), .limit_adjust_present_i(limit_adjust_present_i),
    .gate_o(gate_o), .charge_en_o(charge_en_o), .charge_low_o(charge_low_o),
    .drain_current_limit_o(drain_current_limit_o), .limit_external_o(limit_external_o),
    .fault_o(fault_o));

  ocs_stage_model ocs_stage_model_i (.clk_i(clk_i), .reset_n_i(reset_n_i), .gate_i(gate_o),
    .charge_en_i(charge_en_o), .charge_low_i(charge_low_o), .bulk_i(bulk), .aux_ok_i(aux_ok),
    .ovp_cmd_i(ovp_cmd), .input_start_o(input_start), .turn_on_o(turn_on),
    .turn_off_o(turn_off), .restart_o(restart), .current_trip_o(current_trip),
    .overvoltage_o(overvoltage));

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report

  // The run needs about 50k cycles; three times that means a hang.
  initial begin
    #(150000 * 100);
    mismatches++;
    final_report();
  end

  task automatic step(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask : step

  task automatic bad(input string m);
    mismatches++;
    $display("BAD %0t %s", $time, m);
  endtask : bad

  task automatic chk_bit(input logic got, input logic exp, input string m);
    n_checks++;
    if (got !== exp) bad(m);
  endtask : chk_bit

  task automatic chk_lim(input logic [ocs_pkg::LIM_W-1:0] got, input int lo, input int hi,
                         input string m);
    n_checks++;
    if ((got >= lo && got <= hi) !== 1'b1) bad(m);
  endtask : chk_lim

  task automatic chk_int(input int got, input int lo, input int hi, input string m);
    n_checks++;
    if (got < lo || got > hi) bad(m);
  endtask : chk_int

  task automatic wait_v(ref logic s, input logic v, input int lim, output int k);
    k = 0;
    while (s !== v && k < lim) begin
      step(1);
      k++;
    end
    if (k >= lim) bad("wait timed out");
  endtask : wait_v

  task automatic rise();
    int k;
    wait_v(gate_o, 1'b0, 300, k);
    wait_v(gate_o, 1'b1, 300, k);
  endtask : rise

  task automatic do_reset(input logic hv);
    reset_n_i = 0;
    high_variant_i = hv;
    step(19);
    chk_bit(gate_o, 1'b0, "gate on in lockout");
    chk_bit(charge_en_o, 1'b0, "charge in lockout");
    chk_lim(drain_current_limit_o, ocs_pkg::LIM_MIN, ocs_pkg::LIM_MIN, "limit reset");
    step(1);
    reset_n_i = 1;
  endtask : do_reset

  task automatic t_charge();
    int k;
    bulk = 1;
    step(1);
    bulk = 0;
    step(20);
    chk_bit(charge_en_o, 1'b0, "glitch accepted");
    chk_bit(charge_en_o, 1'b0, "charge without input");
    limit_adjust_present_i = 1;
    step(10);
    chk_bit(limit_external_o, 1'b1, "external limit");
    limit_adjust_present_i = 0;
    step(10);
    chk_bit(limit_external_o, 1'b0, "default limit");
    bulk = 1;
    wait_v(charge_en_o, 1'b1, 20, k);
    chk_int(k, 0, 19, "no charge");
    bulk = 0;
    wait_v(charge_en_o, 1'b0, 20, k);
    chk_int(k, 0, 19, "charge without input");
    bulk = 1;
  endtask : t_charge

  task automatic t_start(input logic low_exp);
    int k;
    wait_v(charge_en_o, 1'b1, 2000, k);
    chk_bit(restart, 1'b1, "early recharge");
    chk_bit(charge_low_o, low_exp, "charge level");
    aux_ok = 1;
    wait_v(charge_en_o, 1'b0, 2000, k);
    chk_bit(turn_on, 1'b1, "charge stopped early");
    wait_v(gate_o, 1'b1, 300, k);
    chk_int(k, 0, 299, "no switching");
    chk_lim(drain_current_limit_o, ocs_pkg::LIM_MIN, ocs_pkg::LIM_MIN + 1, "ramp start");
  endtask : t_start

  task automatic t_osc(input int per, input int dev);
    int tot, p, a, b, k, mn, mx;
    tot = 0;
    mn = 9999;
    mx = 0;
    while (tot < ocs_pkg::JIT_HALF_CYC + 2000) begin
      wait_v(current_trip, 1'b1, 200, k);
      wait_v(gate_o, 1'b0, 20, a);
      chk_int(a, 0, 8, "on past trip");
      wait_v(gate_o, 1'b1, 300, b);
      p = k + a + b;
      chk_int(p, per - dev - 1, per + dev + 1, "period");
      mn = (p < mn) ? p : mn;
      mx = (p > mx) ? p : mx;
      tot += p;
    end
    chk_int(mx - mn, dev, 2 * dev + 2, "jitter swing");
    k = ocs_pkg::LIM_MIN + tot / ocs_pkg::SS_STEP_CYC;
    chk_lim(drain_current_limit_o, k - 1, k + 2, "ramp");
  endtask : t_osc

  task automatic t_down_high();
    int k, v;
    aux_ok = 0;
    wait_v(turn_off, 1'b1, 1000, k);
    step(40);
    v = 0;
    repeat (150) begin
      step(1);
      v += (gate_o !== 1'b0);
    end
    chk_int(v, 0, 0, "switching below off");
    chk_bit(charge_en_o, 1'b0, "early recharge");
  endtask : t_down_high

  task automatic t_ovp();
    int k, a;
    logic g;
    ovp_cmd = 1;
    repeat (3) rise();
    ovp_cmd = 0;
    rise();
    rise();
    chk_bit(fault_o, 1'b0, "three cycles fault");
    ovp_cmd = 1;
    k = 0;
    for (a = 0; a < 1000 && fault_o !== 1'b1; a++) begin
      g = gate_o;
      step(1);
      if (gate_o === 1'b1 && g !== 1'b1) k++;
    end
    chk_int(k, 3, 4, "ovp count");
    ovp_cmd = 0;
    aux_ok = 0;
    step(20);
    chk_bit(gate_o, 1'b0, "switching after ovp");
    chk_bit(charge_low_o, 1'b1, "fault charge level");
    chk_bit(charge_en_o, 1'b0, "early recharge");
  endtask : t_ovp

  task automatic t_down_low();
    int v;
    bulk = 0;
    aux_ok = 0;
    v = 0;
    repeat (1500) begin
      step(1);
      v += (charge_en_o !== 1'b0);
    end
    chk_int(v, 0, 0, "recharge low input");
    chk_bit(gate_o, 1'b0, "switching after down");
    bulk = 1;
    step(50);
    chk_bit(charge_en_o, 1'b0, "inhibit left");
  endtask : t_down_low

  initial begin
    do_reset(1'b0);
    t_charge();
    t_start(1'b0);
    t_osc(ocs_pkg::PER_LOW_CYC, ocs_pkg::DEV_LOW_CYC);
    t_down_high();
    t_start(1'b0);
    t_ovp();
    t_start(1'b1);
    t_down_low();
    do_reset(1'b1);
    t_start(1'b0);
    t_osc(ocs_pkg::PER_HIGH_CYC, ocs_pkg::DEV_HIGH_CYC);
    final_report();
  end
endmodule : offline_converter_sequencer_test
`default_nettype wire
